// ===== timing_out_pkg.sv
package timing_out_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_ARM = 8'h00;
	localparam logic [7:0] OFS_CLEAR = 8'h04;
	localparam logic [7:0] OFS_SEL = 8'h08;
	localparam logic [7:0] OFS_TYPE = 8'h0c;
	localparam logic [7:0] OFS_START = 8'h10;
	localparam logic [7:0] OFS_END = 8'h14;
	localparam logic [7:0] OFS_INTERVAL = 8'h18;
	localparam logic [7:0] OFS_MAPMODE = 8'h1c;
	localparam logic [7:0] OFS_PORTS = 8'h20;
	localparam logic [7:0] OFS_DISPLAY = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int PORTS_DASH_LSB = 16;
	localparam logic signed [31:0] RST_START = 32'sh0000_03e8;
	localparam logic signed [31:0] RST_END = 32'sh0000_2710;
	localparam logic [31:0] RST_INTERVAL = 32'h0000_00c8;
	localparam logic [15:0] RST_PORT_CH = 16'h0123;
	localparam logic [15:0] RST_DISPLAY_CH = 16'h0123;

	// ------------------------------------------------------------
	// output types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		TYPE_NONE = 4'h0,
		TYPE_GATE = 4'h1,
		TYPE_P200NS = 4'h2,
		TYPE_P10US = 4'h3,
		TYPE_P100US = 4'h4,
		TYPE_P1MS = 4'h5,
		TYPE_LEVEL = 4'h6,
		TYPE_M1US = 4'h7,
		TYPE_M10US = 4'h8,
		TYPE_M100US = 4'h9,
		TYPE_M1MS = 4'ha
	} out_type_t;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int WIDTH_200NS_NS = 200;
	localparam int WIDTH_1US_NS = 1000;
	localparam int WIDTH_10US_NS = 10000;
	localparam int WIDTH_100US_NS = 100000;
	localparam int WIDTH_1MS_NS = 1000000;
	localparam int CYC_200NS = (WIDTH_200NS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_1US = (WIDTH_1US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_10US = (WIDTH_10US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_100US = (WIDTH_100US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_1MS = (WIDTH_1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ===== timing_out.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - sixteen channels, each picked by hex index
// - per-channel armed flag, cleared after reset
// - query shows armed, or level for manual
// - output starts crossing start toward end
// - gate high between start and end
// - pulse type runs once, then self-clears
// - resume same direction continues, no repeats
// - no pulses when moving the wrong way
// - clear after stop blocks further pulses
// - manual level: arm high, clear low
// - manual pulse: one pulse per arm
// - display-linked or fixed port mapping
// - fixed port follows channel regardless of display
// - mode change only with all motors stopped
// - four port digits, dash keeps port
// - duplicate channel assignment is rejected
// - assignment stored always, used only fixed
// - readback gives four digits, first port first
// - reassign applies once old, new stopped
// - display switching allowed, routing unchanged in fixed mode
// - type codes none, gate, pulses, manual
// - signed symmetric 31-bit start and end
// - pulse spacing interval, default 200 steps
module timing_out #(
	parameter int NUM_CH = 16,
	parameter int NUM_PORTS = 4,
	parameter int CYC_PULSE_1MS = timing_out_pkg::CYC_1MS
) (
	// clock, reset, enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// motion logic
	input wire logic [NUM_CH*32-1:0] motor_pos,
	input wire logic [NUM_CH-1:0] motor_step,
	input wire logic [NUM_CH-1:0] motor_dir,
	input wire logic [NUM_CH-1:0] motor_busy,
	// timing output ports
	output logic [NUM_PORTS-1:0] timing_port
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [NUM_CH-1:0] armed;
	logic [NUM_CH-1:0] level;
	logic [NUM_CH-1:0] chan_out;
	logic [3:0] out_type [NUM_CH];
	logic signed [31:0] start_pos [NUM_CH];
	logic signed [31:0] end_pos [NUM_CH];
	logic [31:0] interval [NUM_CH];
	logic signed [31:0] mark [NUM_CH];
	logic [15:0] pulse_cnt [NUM_CH];
	logic [3:0] sel_ch;
	logic fixed_mode;
	logic [15:0] port_ch;
	logic [15:0] act_ch;
	logic [15:0] display_ch;
	logic rej_assign;
	logic rej_mode;
	logic wr_pend;
	logic rd_pend;
	logic [7:0] bus_addr;
	logic [NUM_CH-1:0] arm_req;
	logic [NUM_CH-1:0] clr_req;
	logic [15:0] next_port_ch;
	logic wr_en;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] nib(input logic [15:0] w, input int k);
		nib = w[15-4*k -: 4];
	endfunction

	function automatic logic has_dup(input logic [15:0] w);
		has_dup = 1'b0;
		for (int a = 0; a < 4; a++) begin
			for (int b = a + 1; b < 4; b++) begin
				if (nib(w, a) == nib(w, b)) begin
					has_dup = 1'b1;
				end
			end
		end
	endfunction

	function automatic logic [15:0] width_of(input logic [3:0] t);
		case (t)
			timing_out_pkg::TYPE_P200NS: width_of = 16'(timing_out_pkg::CYC_200NS);
			timing_out_pkg::TYPE_P10US: width_of = 16'(timing_out_pkg::CYC_10US);
			timing_out_pkg::TYPE_P100US: width_of = 16'(timing_out_pkg::CYC_100US);
			timing_out_pkg::TYPE_P1MS: width_of = 16'(CYC_PULSE_1MS);
			timing_out_pkg::TYPE_M1US: width_of = 16'(timing_out_pkg::CYC_1US);
			timing_out_pkg::TYPE_M10US: width_of = 16'(timing_out_pkg::CYC_10US);
			timing_out_pkg::TYPE_M100US: width_of = 16'(timing_out_pkg::CYC_100US);
			timing_out_pkg::TYPE_M1MS: width_of = 16'(CYC_PULSE_1MS);
			default: width_of = 16'h0001;
		endcase
	endfunction

	function automatic logic is_pulse(input logic [3:0] t);
		is_pulse = (t >= timing_out_pkg::TYPE_P200NS) && (t <= timing_out_pkg::TYPE_P1MS);
	endfunction

	function automatic logic is_manual(input logic [3:0] t);
		is_manual = (t >= timing_out_pkg::TYPE_LEVEL) && (t <= timing_out_pkg::TYPE_M1MS);
	endfunction

	// ------------------------------------------------------------
	// bus slave: writes zero-wait, reads one wait state
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			bus_addr <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (ce) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			hreadyout <= 1'b1;
			if (hsel && hready && htrans[1]) begin
				bus_addr <= haddr[7:0];
				wr_pend <= hwrite;
				rd_pend <= !hwrite;
				// read data is formed after any write in flight lands
				hreadyout <= hwrite;
			end
		end
	end

	assign wr_en = wr_pend && ce;
	assign arm_req = (wr_en && bus_addr == timing_out_pkg::OFS_ARM) ? hwdata[NUM_CH-1:0] : '0;
	assign clr_req = (wr_en && bus_addr == timing_out_pkg::OFS_CLEAR) ? hwdata[NUM_CH-1:0] : '0;

	always_comb begin
		for (int k = 0; k < NUM_PORTS; k++) begin
			if (hwdata[timing_out_pkg::PORTS_DASH_LSB + k]) begin
				next_port_ch[15-4*k -: 4] = nib(port_ch, k);
			end else begin
				next_port_ch[15-4*k -: 4] = nib(hwdata[15:0], k);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ce && rd_pend) begin
			case (bus_addr)
				timing_out_pkg::OFS_ARM: begin
					for (int i = 0; i < NUM_CH; i++) begin
						hrdata[i] <= is_manual(out_type[i]) ? chan_out[i] : armed[i];
					end
					hrdata[31:NUM_CH] <= '0;
				end
				timing_out_pkg::OFS_SEL: hrdata <= {28'h0000000, sel_ch};
				timing_out_pkg::OFS_TYPE: hrdata <= {28'h0000000, out_type[sel_ch]};
				timing_out_pkg::OFS_START: hrdata <= start_pos[sel_ch];
				timing_out_pkg::OFS_END: hrdata <= end_pos[sel_ch];
				timing_out_pkg::OFS_INTERVAL: hrdata <= interval[sel_ch];
				timing_out_pkg::OFS_MAPMODE: hrdata <= {31'h00000000, fixed_mode};
				timing_out_pkg::OFS_PORTS: hrdata <= {16'h0000, port_ch};
				timing_out_pkg::OFS_DISPLAY: hrdata <= {16'h0000, display_ch};
				timing_out_pkg::OFS_STATUS: hrdata <= {30'h00000000, rej_mode, rej_assign};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_ch <= 4'h0;
			for (int i = 0; i < NUM_CH; i++) begin
				out_type[i] <= timing_out_pkg::TYPE_NONE;
				start_pos[i] <= timing_out_pkg::RST_START;
				end_pos[i] <= timing_out_pkg::RST_END;
				interval[i] <= timing_out_pkg::RST_INTERVAL;
			end
		end else if (wr_en) begin
			case (bus_addr)
				timing_out_pkg::OFS_SEL: sel_ch <= hwdata[3:0];
				timing_out_pkg::OFS_TYPE: begin
					// codes past the last manual pulse are dropped
					if (hwdata[3:0] <= timing_out_pkg::TYPE_M1MS) begin
						out_type[sel_ch] <= hwdata[3:0];
					end
				end
				timing_out_pkg::OFS_START: begin
					if (hwdata != 32'h8000_0000) begin
						start_pos[sel_ch] <= hwdata;
					end
				end
				timing_out_pkg::OFS_END: begin
					if (hwdata != 32'h8000_0000) begin
						end_pos[sel_ch] <= hwdata;
					end
				end
				timing_out_pkg::OFS_INTERVAL: begin
					if (hwdata != 32'h0000_0000 && !hwdata[31]) begin
						interval[sel_ch] <= hwdata;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// port mapping
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fixed_mode <= 1'b0;
			rej_mode <= 1'b0;
			port_ch <= timing_out_pkg::RST_PORT_CH;
			rej_assign <= 1'b0;
			display_ch <= timing_out_pkg::RST_DISPLAY_CH;
		end else if (wr_en) begin
			case (bus_addr)
				timing_out_pkg::OFS_MAPMODE: begin
					if (motor_busy == '0) begin
						fixed_mode <= hwdata[0];
						rej_mode <= 1'b0;
					end else begin
						rej_mode <= 1'b1;
					end
				end
				timing_out_pkg::OFS_PORTS: begin
					if (has_dup(next_port_ch)) begin
						rej_assign <= 1'b1;
					end else begin
						port_ch <= next_port_ch;
						rej_assign <= 1'b0;
					end
				end
				// display may change in either mode
				timing_out_pkg::OFS_DISPLAY: display_ch <= hwdata[15:0];
				default: begin
				end
			endcase
		end
	end

	// stored assignment reaches routing once both channels are idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_ch <= timing_out_pkg::RST_PORT_CH;
		end else if (ce) begin
			for (int k = 0; k < NUM_PORTS; k++) begin
				if (!motor_busy[nib(act_ch, k)] && !motor_busy[nib(port_ch, k)]) begin
					act_ch[15-4*k -: 4] <= nib(port_ch, k);
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timing_port <= '0;
		end else if (ce) begin
			for (int k = 0; k < NUM_PORTS; k++) begin
				if (fixed_mode) begin
					timing_port[k] <= chan_out[nib(act_ch, k)];
				end else begin
					timing_port[k] <= chan_out[nib(display_ch, k)];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// channel engines
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed <= '0;
			level <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				mark[i] <= 32'sh0000_0000;
				pulse_cnt[i] <= 16'h0000;
			end
		end else if (ce) begin
			for (int i = 0; i < NUM_CH; i++) begin
				logic signed [31:0] p;
				logic fwd;
				logic reach;
				logic past_end;
				p = motor_pos[i*32 +: 32];
				fwd = end_pos[i] >= start_pos[i];
				reach = fwd ? (p >= mark[i]) : (p <= mark[i]);
				past_end = fwd ? (p >= end_pos[i]) : (p <= end_pos[i]);
				if (pulse_cnt[i] != 16'h0000) begin
					pulse_cnt[i] <= pulse_cnt[i] - 16'h0001;
				end
				if (clr_req[i]) begin
					armed[i] <= 1'b0;
					level[i] <= 1'b0;
				end else if (arm_req[i]) begin
					if (out_type[i] == timing_out_pkg::TYPE_LEVEL) begin
						level[i] <= 1'b1;
					end else if (is_manual(out_type[i])) begin
						pulse_cnt[i] <= width_of(out_type[i]);
					end else if (out_type[i] != timing_out_pkg::TYPE_NONE) begin
						armed[i] <= 1'b1;
						mark[i] <= start_pos[i];
					end
				end else if (armed[i] && is_pulse(out_type[i]) && motor_step[i]
						&& motor_dir[i] == fwd) begin
					// mark only advances, so re-covered ground stays quiet
					if (reach && (fwd ? (p <= end_pos[i]) : (p >= end_pos[i]))) begin
						pulse_cnt[i] <= width_of(out_type[i]);
						if (fwd) begin
							mark[i] <= mark[i] + $signed(interval[i]);
						end else begin
							mark[i] <= mark[i] - $signed(interval[i]);
						end
					end
					if (past_end) begin
						armed[i] <= 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_out <= '0;
		end else if (ce) begin
			for (int i = 0; i < NUM_CH; i++) begin
				logic signed [31:0] q;
				logic signed [31:0] lo;
				logic signed [31:0] hi;
				q = motor_pos[i*32 +: 32];
				lo = (end_pos[i] >= start_pos[i]) ? start_pos[i] : end_pos[i];
				hi = (end_pos[i] >= start_pos[i]) ? end_pos[i] : start_pos[i];
				case (out_type[i])
					timing_out_pkg::TYPE_GATE: chan_out[i] <= armed[i] && q >= lo && q <= hi;
					timing_out_pkg::TYPE_LEVEL: chan_out[i] <= level[i];
					timing_out_pkg::TYPE_NONE: chan_out[i] <= 1'b0;
					default: chan_out[i] <= pulse_cnt[i] != 16'h0000;
				endcase
			end
		end
	end

	// hsize is accepted as word only; narrower sizes act as words
	logic unused_ok;
	assign unused_ok = ^{hsize, haddr[31:8], hwdata[31:20]};

endmodule

`default_nettype wire

// ===== timing_out_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module timing_out_asserts #(
	parameter int NUM_PORTS = 4
) (
	// bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// outputs
	input wire logic [NUM_PORTS-1:0] timing_port
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// ----------
	// sequences
	// ----------
	sequence rd_taken;
		hsel && hready && htrans[1] && !hwrite && ce;
	endsequence
	sequence wr_taken;
		hsel && hready && htrans[1] && hwrite && ce;
	endsequence
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	// ----------
	// properties
	// ----------
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	read_wait_a: assert property (rd_taken |=> one_wait)
		else $error("read lacks one wait state");
	write_nowait_a: assert property (wr_taken |=> hreadyout)
		else $error("write stalled");
	// a frozen enable legally stretches the wait state
	ready_once_a: assert property (!hreadyout && ce |=> hreadyout)
		else $error("wait state too long");
	ready_cause_a: assert property ($fell(hreadyout) |-> $past(hsel && hready && htrans[1] && !hwrite && ce))
		else $error("wait state without read");
	reset_quiet_a: assert property ($rose(hresetn) |-> timing_port == '0 ##1 timing_port == '0)
		else $error("port active after reset");
	freeze_port_a: assert property (!ce |=> $stable(timing_port))
		else $error("port moved while disabled");
	freeze_bus_a: assert property (!ce |=> $stable(hreadyout) && $stable(hrdata))
		else $error("bus moved while disabled");
	port_reg_a: assert property ($changed(timing_port) |-> $past(ce))
		else $error("port changed without enable");
endmodule
bind timing_out timing_out_asserts #(.NUM_PORTS(NUM_PORTS)) i_timing_out_asserts (.hclk(hclk), .hresetn(hresetn),
	.ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .timing_port(timing_port));
`default_nettype wire

// ===== motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module motor_model (
	// clock
	input wire logic hclk,
	// motion
	output logic [511:0] motor_pos,
	output logic [15:0] motor_step,
	output var logic [15:0] motor_dir,
	output logic [15:0] motor_busy
);
	logic signed [31:0] pos = 32'sh0;
	logic moving = 1'b0;
	logic park_busy = 1'b0;
	initial motor_step = 16'h0;
	initial motor_dir = 16'hffff;
	assign motor_pos = {480'h0, pos};
	// other channels only ever look busy, which blocks mode changes
	assign motor_busy = {{15{park_busy}}, moving | park_busy};
	// ----------
	// one step every five cycles
	// ----------
	// spacing leaves room for the short motion pulse between steps
	task automatic move(input int target);
		moving <= 1'b1;
		motor_dir <= {16{target > pos}};
		while (pos != target) begin
			@(posedge hclk);
			pos <= (target > pos) ? pos + 1 : pos - 1;
			motor_step <= 16'h0001;
			@(posedge hclk);
			motor_step <= 16'h0000;
			repeat (3) @(posedge hclk);
		end
		moving <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== timing_out_tb.sv
`timescale 1ns/1ps
`default_nettype none
module timing_out_tb;
	// ----------
	// signals
	// ----------
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic ce = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [511:0] motor_pos;
	logic [15:0] motor_step;
	logic [15:0] motor_dir;
	logic [15:0] motor_busy;
	logic [3:0] timing_port;
	logic [31:0] seed = 32'h9a752e2b;
	logic [31:0] q;
	logic [31:0] v;
	logic armed = 1'b0;
	int bad_count = 0;
	int checked = 0;
	int rises = 0;
	int hi_cnt = 0;
	int mark = 0;
	int wid [4] = '{timing_out_pkg::CYC_1US, timing_out_pkg::CYC_10US, timing_out_pkg::CYC_100US, 20};
	always #50 hclk = ~hclk;
	always @(posedge timing_port[0]) rises++;
	always @(posedge hclk)
		if (timing_port[0] === 1'b1)
			hi_cnt++;
	timing_out #(.CYC_PULSE_1MS(20)) i_timing_out (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .motor_pos(motor_pos), .motor_step(motor_step),
		.motor_dir(motor_dir), .motor_busy(motor_busy), .timing_port(timing_port));
	motor_model i_motor_model (.hclk(hclk), .motor_pos(motor_pos), .motor_step(motor_step),
		.motor_dir(motor_dir), .motor_busy(motor_busy));
	// ----------
	// helpers
	// ----------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// pulses a forward move to hi should give; marks already passed stay spent
	function automatic int npul(input int hi);
		int n;
		n = 0;
		while (mark <= hi && mark <= 35) begin
			n++;
			mark += 10;
		end
		return n;
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		chk($sformatf("register %h", a), exp, q);
	endtask
	task automatic arm();
		wr(timing_out_pkg::OFS_ARM, 32'h1);
		armed = 1'b1;
		mark = 10;
	endtask
	task automatic go(input int target);
		int e;
		e = 0;
		if (armed && target > i_motor_model.pos) begin
			e = npul(target);
			armed = (target < 35);
		end
		rises = 0;
		i_motor_model.move(target);
		repeat (4) @(posedge hclk);
		chk("pulse count", e, rises);
	endtask
	// all four ports at once, so a stray high on any port is seen
	task automatic port_is(input logic [3:0] exp);
		repeat (4) @(posedge hclk);
		chk("port", {28'h0, exp}, {28'h0, timing_port});
	endtask
	// ----------
	// sequence
	// ----------
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(timing_out_pkg::OFS_START, timing_out_pkg::RST_START);
		rd(timing_out_pkg::OFS_END, timing_out_pkg::RST_END);
		rd(timing_out_pkg::OFS_INTERVAL, timing_out_pkg::RST_INTERVAL);
		rd(timing_out_pkg::OFS_PORTS, {16'h0, timing_out_pkg::RST_PORT_CH});
		rd(timing_out_pkg::OFS_ARM, 32'h0);
		rd(8'h3c, 32'h0);
		for (int i = 0; i < 4; i++) begin
			v = (xs() & 32'h7fffffff) | 32'h1;
			wr(timing_out_pkg::OFS_INTERVAL, v);
			rd(timing_out_pkg::OFS_INTERVAL, v);
			wr(timing_out_pkg::OFS_START, 32'h80000000);
			rd(timing_out_pkg::OFS_START, timing_out_pkg::RST_START);
		end
		for (int t = 0; t < 12; t++) begin
			wr(timing_out_pkg::OFS_TYPE, t);
			rd(timing_out_pkg::OFS_TYPE, (t < 11) ? t : 10);
		end
		i_motor_model.park_busy <= 1'b1;
		wr(timing_out_pkg::OFS_MAPMODE, 32'h1);
		rd(timing_out_pkg::OFS_STATUS, 32'h2);
		i_motor_model.park_busy <= 1'b0;
		wr(timing_out_pkg::OFS_MAPMODE, 32'h1);
		rd(timing_out_pkg::OFS_MAPMODE, 32'h1);
		wr(timing_out_pkg::OFS_PORTS, 32'h1120);
		rd(timing_out_pkg::OFS_STATUS, 32'h1);
		wr(timing_out_pkg::OFS_PORTS, 32'he4567);
		rd(timing_out_pkg::OFS_PORTS, 32'h4123);
		wr(timing_out_pkg::OFS_PORTS, 32'he0000);
		wr(timing_out_pkg::OFS_DISPLAY, 32'h4567);
		wr(timing_out_pkg::OFS_SEL, 32'h0);
		wr(timing_out_pkg::OFS_TYPE, 32'h6);
		wr(timing_out_pkg::OFS_ARM, 32'h1);
		ce <= 1'b0;
		repeat (3) @(posedge hclk);
		ce <= 1'b1;
		port_is(4'h1);
		rd(timing_out_pkg::OFS_ARM, 32'h1);
		wr(timing_out_pkg::OFS_CLEAR, 32'h1);
		port_is(4'h0);
		for (int i = 0; i < 4; i++) begin
			wr(timing_out_pkg::OFS_TYPE, 7 + i);
			hi_cnt = 0;
			rises = 0;
			wr(timing_out_pkg::OFS_ARM, 32'h1);
			repeat (wid[i] + 6) @(posedge hclk);
			chk("manual width", wid[i], hi_cnt);
			chk("manual count", 1, rises);
		end
		wr(timing_out_pkg::OFS_TYPE, 32'h2);
		wr(timing_out_pkg::OFS_START, 32'd10);
		wr(timing_out_pkg::OFS_END, 32'd35);
		wr(timing_out_pkg::OFS_INTERVAL, 32'd10);
		arm();
		go(40);
		rd(timing_out_pkg::OFS_ARM, 32'h0);
		go(0);
		arm();
		go(-10);
		go(22);
		go(15);
		go(40);
		arm();
		go(0);
		go(22);
		wr(timing_out_pkg::OFS_CLEAR, 32'h1);
		armed = 1'b0;
		go(40);
		wr(timing_out_pkg::OFS_TYPE, 32'h1);
		wr(timing_out_pkg::OFS_ARM, 32'h1);
		i_motor_model.move(20);
		port_is(4'h1);
		wr(timing_out_pkg::OFS_CLEAR, 32'h1);
		port_is(4'h0);
		// second channel proves the second port routes as well as the first
		wr(timing_out_pkg::OFS_SEL, 32'h1);
		wr(timing_out_pkg::OFS_TYPE, 32'h6);
		wr(timing_out_pkg::OFS_ARM, 32'h2);
		port_is(4'h2);
		rd(timing_out_pkg::OFS_ARM, 32'h2);
		wr(timing_out_pkg::OFS_MAPMODE, 32'h0);
		rd(timing_out_pkg::OFS_MAPMODE, 32'h0);
		port_is(4'h0);
		wr(timing_out_pkg::OFS_DISPLAY, 32'h1456);
		port_is(4'h1);
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge hclk);
		bad_count++;
		end_sim();
	end
endmodule
`default_nettype wire
